// file: verilog/reset_cause_status.sv
// Contract
// R1: Bit 29 is set when a high-voltage-detect reset occurs and reads 0 otherwise.
// R2: Bit 9 is set when a configuration-mismatch reset occurs and stays clear otherwise.
// R3: Bit 8 is a software bit, reset 0, where 1 keeps the regulator on in sleep and 0 lets it track in standby.
// R4: Bit 7 is set when the active-low master-clear pin is driven low.
// R5: Bit 6 is set when a software reset is executed.
// R6: Bit 4 is set when the watchdog timer expires.
// R7: Bit 3 is set when the device wakes having been in sleep mode.
// R8: Bit 2 is set when the device wakes having been in idle mode.
// R9: Bit 1 is set on a brown-out reset and reads 1 after power-on reset.
// R10: Bit 0 is set on a power-on reset and reads 1 after power-on reset.
// R11: Software writes 0 to the brown-out and power-on flags after reading them to see the next event.
// R12: Bits 28 to 10 are unimplemented, read as zero and ignore writes.
// R13: Every hardware flag stays set until software writes it to 0, so several may read 1 together.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_status
	import reset_cause_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output var  logic [DATA_W-1:0] rdata,
	input  wire logic              high_voltage_detect,
	input  wire logic              config_mismatch,
	input  wire logic              master_clear_pin_n,
	input  wire logic              software_reset,
	input  wire logic              watchdog_timer_expired,
	input  wire logic              brownout_detect,
	input  wire logic              enter_sleep,
	input  wire logic              enter_idle,
	input  wire logic              wake_event,
	output var  logic              regulator_sleep_keep_on,
	output var  logic              regulator_standby,
	output var  logic              in_sleep,
	output var  logic              in_idle,
	output var  logic              irq
);

	logic [DATA_W-1:0] hw_set;
	logic [DATA_W-1:0] sw_we;
	logic [DATA_W-1:0] sw_val;
	logic [DATA_W-1:0] flags;
	logic [DATA_W-1:0] cause_view;
	logic [DATA_W-1:0] int_status_reg;
	logic [DATA_W-1:0] int_status_next;
	logic [DATA_W-1:0] int_mask_reg;
	logic [DATA_W-1:0] mode_view;
	logic              keep_on_reg;
	logic              keep_on_next;
	logic              any_reset_cause;
	logic              wake_sleep;
	logic              wake_idle;
	power_mode_t       mode_reg;
	power_mode_t       mode_next;
	last_cause_t       last_reg;
	last_cause_t       last_next;

	// A reset-type event always ends a low-power mode
	assign any_reset_cause = high_voltage_detect
		| config_mismatch
		| ~master_clear_pin_n
		| software_reset
		| watchdog_timer_expired
		| brownout_detect;

	// Power mode tracking
	always_comb begin
		mode_next = mode_reg;
		wake_sleep = 1'b0;
		wake_idle = 1'b0;
		case (mode_reg)
			MODE_RUN: begin
				if (any_reset_cause) begin
					mode_next = MODE_RUN;
				end else if (enter_sleep) begin
					mode_next = MODE_SLEEP;
				end else if (enter_idle) begin
					mode_next = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (wake_event || any_reset_cause) begin
					mode_next = MODE_RUN;
					wake_idle = 1'b1; // [R8]
				end
			end
			MODE_SLEEP: begin
				if (wake_event || any_reset_cause) begin
					mode_next = MODE_RUN;
					wake_sleep = 1'b1; // [R7]
				end
			end
			default: begin
				mode_next = MODE_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mode_reg <= MODE_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Hardware set requests, one pulse per cycle of the event
	always_comb begin
		hw_set = '0;
		hw_set[BIT_HV] = high_voltage_detect; // [R1]
		hw_set[BIT_CM] = config_mismatch; // [R2]
		hw_set[BIT_EXT] = ~master_clear_pin_n; // [R4]
		hw_set[BIT_SW] = software_reset; // [R5]
		hw_set[BIT_WDT] = watchdog_timer_expired; // [R6]
		hw_set[BIT_SLEEP] = wake_sleep; // [R7]
		hw_set[BIT_IDLE] = wake_idle; // [R8]
		hw_set[BIT_BOR] = brownout_detect; // [R9]
	end

	// Software access: direct write, write-one-to-clear and write-one-to-set views
	always_comb begin
		sw_we = '0;
		sw_val = '0;
		if (wr_stb) begin
			case (addr)
				ADDR_CAUSE: begin
					sw_we = '1;
					sw_val = wdata;
				end
				ADDR_CAUSE_CLR: begin
					sw_we = wdata;
					sw_val = '0;
				end
				ADDR_CAUSE_SET: begin
					sw_we = wdata;
					sw_val = '1;
				end
				default: begin
					sw_we = '0;
					sw_val = '0;
				end
			endcase
		end
	end

	// Only implemented flag positions get storage
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_flag
			if (FLAG_MASK[gi]) begin : g_cell
				flag_cell #(
					.RESET_VALUE (CAUSE_RST[gi])
				) u_cell (
					.sys_clk   (sys_clk),
					.srst      (srst),
					.set_pulse (hw_set[gi]),
					.wr_en     (sw_we[gi]),
					.wr_value  (sw_val[gi]),
					.q         (flags[gi])
				); // [R9] [R10] [R11] [R13]
			end else begin : g_none
				assign flags[gi] = 1'b0; // [R12]
			end
		end
	endgenerate

	// Power-on flag: srst stands for power-on, so the cell reset value is its set [R10]

	always_comb begin
		keep_on_next = keep_on_reg;
		if (sw_we[BIT_KEEP_ON]) begin
			keep_on_next = sw_val[BIT_KEEP_ON];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			keep_on_reg <= KEEP_ON_RST; // [R3]
		end else begin
			keep_on_reg <= keep_on_next;
		end
	end

	// Unimplemented bits come out as zero [R12]
	always_comb begin
		cause_view = flags & FLAG_MASK;
		cause_view[BIT_KEEP_ON] = keep_on_reg;
	end

	// Regulator control changes on the same edge as the mode register, from flops fed by the next mode [R3]
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			regulator_sleep_keep_on <= KEEP_ON_RST;
			regulator_standby <= 1'b0;
			in_sleep <= 1'b0;
			in_idle <= 1'b0;
		end else begin
			regulator_sleep_keep_on <= keep_on_next;
			regulator_standby <= (mode_next == MODE_SLEEP) && !keep_on_next; // [R3]
			in_sleep <= (mode_next == MODE_SLEEP);
			in_idle <= (mode_next == MODE_IDLE);
		end
	end

	// Most recent cause; on a tie the higher bit position wins
	always_comb begin
		last_next = last_reg;
		if (hw_set[BIT_HV]) begin
			last_next = LAST_HV;
		end else if (hw_set[BIT_CM]) begin
			last_next = LAST_CM;
		end else if (hw_set[BIT_EXT]) begin
			last_next = LAST_EXT;
		end else if (hw_set[BIT_SW]) begin
			last_next = LAST_SW;
		end else if (hw_set[BIT_WDT]) begin
			last_next = LAST_WDT;
		end else if (hw_set[BIT_SLEEP]) begin
			last_next = LAST_SLEEP;
		end else if (hw_set[BIT_IDLE]) begin
			last_next = LAST_IDLE;
		end else if (hw_set[BIT_BOR]) begin
			last_next = LAST_BOR;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			last_reg <= LAST_NONE;
		end else begin
			last_reg <= last_next;
		end
	end

	always_comb begin
		mode_view = '0;
		mode_view[MODE_FIELD_LSB +: 3] = mode_reg;
		mode_view[LAST_FIELD_LSB +: 4] = last_reg;
	end

	// Interrupt status: set wins over a write-one-to-clear in the same cycle
	always_comb begin
		int_status_next = int_status_reg;
		if (wr_stb && addr == ADDR_INT_STATUS) begin
			int_status_next = int_status_next & ~wdata;
		end
		int_status_next = (int_status_next | hw_set) & FLAG_MASK;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			int_status_reg <= '0;
		end else begin
			int_status_reg <= int_status_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			int_mask_reg <= '0;
		end else if (wr_stb && addr == ADDR_INT_MASK) begin
			int_mask_reg <= wdata & FLAG_MASK;
		end
	end

	// Registered, so it lags the status bit by one cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_reg & int_mask_reg);
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (rd_stb) begin
			case (addr)
				ADDR_CAUSE: begin
					rdata <= cause_view;
				end
				ADDR_CAUSE_CLR: begin
					rdata <= cause_view;
				end
				ADDR_CAUSE_SET: begin
					rdata <= cause_view;
				end
				ADDR_INT_STATUS: begin
					rdata <= int_status_reg;
				end
				ADDR_INT_MASK: begin
					rdata <= int_mask_reg;
				end
				ADDR_MODE: begin
					rdata <= mode_view;
				end
				default: begin
					rdata <= '0;
				end
			endcase
		end else begin
			rdata <= '0;
		end
	end

endmodule
`default_nettype wire

// file: pkg/reset_cause_pkg.sv
`default_nettype none
package reset_cause_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] ADDR_CAUSE      = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE_CLR  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CAUSE_SET  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK   = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_MODE       = 8'h14;

	localparam int BIT_HV      = 29;
	localparam int BIT_CM      = 9;
	localparam int BIT_KEEP_ON = 8;
	localparam int BIT_EXT     = 7;
	localparam int BIT_SW      = 6;
	localparam int BIT_WDT     = 4;
	localparam int BIT_SLEEP   = 3;
	localparam int BIT_IDLE    = 2;
	localparam int BIT_BOR     = 1;
	localparam int BIT_POR     = 0;

	localparam logic [DATA_W-1:0] FLAG_MASK  = 32'h2000_02DF;
	localparam logic [DATA_W-1:0] CAUSE_RST  = 32'h0000_0003;
	localparam logic              KEEP_ON_RST = 1'h0;

	localparam int MODE_FIELD_LSB = 0;
	localparam int LAST_FIELD_LSB = 8;

	typedef enum logic [3:0] {
		LAST_NONE  = 4'h0,
		LAST_HV    = 4'h1,
		LAST_CM    = 4'h2,
		LAST_EXT   = 4'h3,
		LAST_SW    = 4'h4,
		LAST_WDT   = 4'h5,
		LAST_BOR   = 4'h6,
		LAST_SLEEP = 4'h7,
		LAST_IDLE  = 4'h8
	} last_cause_t;

	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_IDLE  = 3'b010,
		MODE_SLEEP = 3'b100
	} power_mode_t;

endpackage
`default_nettype wire

// file: verilog/flag_cell.sv
`timescale 1ns/100ps
`default_nettype none
module flag_cell #(
	parameter logic RESET_VALUE = 1'b0
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic set_pulse,
	input  wire logic wr_en,
	input  wire logic wr_value,
	output var  logic q
);

	// Hardware set wins over a software write in the same cycle [R13]
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			q <= RESET_VALUE;
		end else if (set_pulse) begin
			q <= 1'b1;
		end else if (wr_en) begin
			q <= wr_value;
		end
	end

endmodule
`default_nettype wire

// file: dv/reset_cause_status_sva.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_status_sva
	import reset_cause_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              srst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              high_voltage_detect,
	input wire logic              config_mismatch,
	input wire logic              master_clear_pin_n,
	input wire logic              software_reset,
	input wire logic              watchdog_timer_expired,
	input wire logic              wake_event,
	input wire logic              in_sleep,
	input wire logic              regulator_sleep_keep_on
);
	// A read of the cause register in the cycle after an event must show its flag
	wire logic rd_c = rd_stb && addr == ADDR_CAUSE;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_HV: assert property (high_voltage_detect ##1 rd_c |=> rdata[BIT_HV]) else $error("hv flag missing");
	AST_CM: assert property (config_mismatch ##1 rd_c |=> rdata[BIT_CM]) else $error("cm flag missing");
	AST_EXT: assert property (!master_clear_pin_n ##1 rd_c |=> rdata[BIT_EXT]) else $error("ext flag missing");
	AST_SW: assert property (software_reset ##1 rd_c |=> rdata[BIT_SW]) else $error("sw flag missing");
	AST_WDT: assert property (watchdog_timer_expired ##1 rd_c |=> rdata[BIT_WDT]) else $error("wdt flag missing");
	AST_SLEEP: assert property ((wake_event && in_sleep) ##1 rd_c |=> rdata[BIT_SLEEP])
		else $error("sleep flag missing");
	AST_RSVD: assert property (rd_c |=> rdata[31:30] == 2'h0 && rdata[28:10] == 19'h0 && !rdata[5])
		else $error("unimplemented bits set");
	AST_KEEP: assert property (wr_stb && addr == ADDR_CAUSE && wdata[BIT_KEEP_ON] |-> ##[1:2] regulator_sleep_keep_on)
		else $error("keep on not applied");
endmodule
bind reset_cause_status reset_cause_status_sva i_sva (.*);
`default_nettype wire

// file: dv/reset_cause_status_bench.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_status_bench
	import reset_cause_pkg::*;
;
	logic              sys_clk = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic              wr_stb = 1'b0;
	logic              rd_stb = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic              enter_sleep = 1'b0;
	logic              enter_idle = 1'b0;
	logic              wake_event = 1'b0;
	logic              regulator_sleep_keep_on;
	logic              regulator_standby;
	logic              in_sleep;
	logic              in_idle;
	logic              irq;
	logic [5:0]        ev = 6'h00;
	logic [DATA_W-1:0] exp_v;
	int                fail_count = 0;
	int                n_checks = 0;
	int                bits [6] = '{BIT_HV, BIT_CM, BIT_EXT, BIT_SW, BIT_WDT, BIT_BOR};
	// One vector drives every reset cause but power-on, which comes from srst; the pin is active low
	wire logic high_voltage_detect = ev[5];
	wire logic config_mismatch = ev[4];
	wire logic master_clear_pin_n = !ev[3];
	wire logic software_reset = ev[2];
	wire logic watchdog_timer_expired = ev[1];
	wire logic brownout_detect = ev[0];

	reset_cause_status i_dut (
		.sys_clk                 (sys_clk),
		.srst                    (srst),
		.addr                    (addr),
		.wdata                   (wdata),
		.wr_stb                  (wr_stb),
		.rd_stb                  (rd_stb),
		.rdata                   (rdata),
		.high_voltage_detect     (high_voltage_detect),
		.config_mismatch         (config_mismatch),
		.master_clear_pin_n      (master_clear_pin_n),
		.software_reset          (software_reset),
		.watchdog_timer_expired  (watchdog_timer_expired),
		.brownout_detect         (brownout_detect),
		.enter_sleep             (enter_sleep),
		.enter_idle              (enter_idle),
		.wake_event              (wake_event),
		.regulator_sleep_keep_on (regulator_sleep_keep_on),
		.regulator_standby       (regulator_standby),
		.in_sleep                (in_sleep),
		.in_idle                 (in_idle),
		.irq                     (irq)
	);

	always #2.5 sys_clk = ~sys_clk;

	task automatic end_of_test;
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Called on a rising edge, so it sees what the edge before registered
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Trailing edge keeps two strobes apart
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		// Read data stands only until the next edge, so it is taken there
		@(posedge sys_clk);
		chk(rdata, e, "rdata");
	endtask

	initial begin
		#20000;
		fail_count++;
		end_of_test;
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(ADDR_CAUSE, CAUSE_RST);
		wr(ADDR_CAUSE, 32'h0);
		rd(ADDR_CAUSE, 32'h0);
		exp_v = 32'h0;
		for (int i = 0; i < 6; i++) begin
			ev <= 6'h20 >> i;
			@(posedge sys_clk);
			ev <= 6'h00;
			exp_v = exp_v | (32'h1 << bits[i]);
			rd(ADDR_CAUSE, exp_v);
		end
		// Clear and set aliases touch only the bits written as one
		wr(ADDR_CAUSE_CLR, 32'h1 << BIT_WDT);
		exp_v = exp_v & ~(32'h1 << BIT_WDT);
		rd(ADDR_CAUSE_SET, exp_v);
		wr(ADDR_CAUSE_SET, 32'h1 << BIT_POR);
		rd(ADDR_CAUSE_CLR, exp_v | 32'h1);
		wr(ADDR_CAUSE, 32'hFFFF_FFFF);
		rd(ADDR_CAUSE, FLAG_MASK | 32'h0000_0100);
		chk(regulator_sleep_keep_on, 32'h1, "keep_on");
		rd(8'h40, 32'h0);
		for (int j = 0; j < 2; j++) begin
			@(posedge sys_clk);
			wr(ADDR_CAUSE, 32'h0);
			enter_sleep <= j[0];
			enter_idle <= !j[0];
			@(posedge sys_clk);
			enter_sleep <= 1'b0;
			enter_idle <= 1'b0;
			@(posedge sys_clk);
			chk(regulator_standby, j, "standby");
			chk(in_sleep, j, "in_sleep");
			chk(in_idle, !j, "in_idle");
			@(posedge sys_clk);
			wake_event <= 1'b1;
			@(posedge sys_clk);
			wake_event <= 1'b0;
			rd(ADDR_CAUSE, j ? 32'h8 : 32'h4);
		end
		// Sleep with the regulator kept on must not ask for standby
		wr(ADDR_CAUSE, 32'h1 << BIT_KEEP_ON);
		enter_sleep <= 1'b1;
		@(posedge sys_clk);
		enter_sleep <= 1'b0;
		@(posedge sys_clk);
		chk(in_sleep, 32'h1, "in_sleep");
		chk(regulator_standby, 32'h0, "standby");
		chk(regulator_sleep_keep_on, 32'h1, "keep_on");
		wake_event <= 1'b1;
		@(posedge sys_clk);
		wake_event <= 1'b0;
		rd(ADDR_CAUSE, 32'h0000_0108);
		// The interrupt output is registered, one edge behind status and mask
		wr(ADDR_INT_STATUS, 32'hFFFF_FFFF);
		wr(ADDR_INT_MASK, 32'h1 << BIT_WDT);
		@(posedge sys_clk);
		chk(irq, 32'h0, "irq");
		ev <= 6'h02;
		@(posedge sys_clk);
		ev <= 6'h00;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk(irq, 32'h1, "irq");
		rd(ADDR_INT_STATUS, 32'h1 << BIT_WDT);
		rd(ADDR_INT_MASK, 32'h1 << BIT_WDT);
		rd(ADDR_MODE, 32'h0000_0501);
		wr(ADDR_INT_MASK, 32'h0);
		@(posedge sys_clk);
		chk(irq, 32'h0, "irq");
		wr(ADDR_INT_MASK, 32'h1 << BIT_WDT);
		@(posedge sys_clk);
		chk(irq, 32'h1, "irq");
		wr(ADDR_INT_STATUS, 32'h1 << BIT_WDT);
		@(posedge sys_clk);
		chk(irq, 32'h0, "irq");
		// A second power-on reset in mid-run brings back the reset values
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		chk(regulator_sleep_keep_on, 32'h0, "keep_on");
		rd(ADDR_CAUSE, CAUSE_RST);
		rd(ADDR_MODE, 32'h0000_0001);
		end_of_test;
	end
endmodule
`default_nettype wire
